// >>> logic/bdsup_top.sv
// Notes on behaviour
// [RULE1] timers enabled or disabled by id mask
// [RULE2] timer command refused while 16k oscillator off
// [RULE3] timer command refused while bandgap off
// [RULE4] timeout written only while its timer disabled
// [RULE5] second timer timeout is 0..65535 seconds
// [RULE6] active-mode supply switch: battery or system
// [RULE7] current active supply readable
// [RULE8] low-power system selection forces system supply
// [RULE9] switch lock blocks switch register writes
// [RULE10] switch lock readable and clearable
// [RULE11] oscillators stable before clock monitor setup
// [RULE12] monitor divide selects 1kHz or 64Hz
// [RULE13] monitor threshold 2, 4, 6 or 8
// [RULE14] monitor lock blocks enable changes
// [RULE15] oscillator and bandgap on before tamper
// [RULE16] tamper sources masked, mask readable
// [RULE17] tamper lock blocks tamper writes
// [RULE18] all status flags in one word
// [RULE19] mask clear, six flags excluded
// [RULE20] voltage and temperature tamper separately enabled
// [RULE21] timers run only with bandgap, 16k clock
// [RULE22] reset clears locks and settings
module bdsup_top
  import bdsup_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic [bdsup_pkg::ADDR_W-1:0] addr,
  input  wire logic [bdsup_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output      logic [bdsup_pkg::DATA_W-1:0] rdata,
  input  wire logic                        fro_tick,
  input  wire logic                        xo_tick,
  input  wire logic                        xo_stable,
  input  wire logic                        ldo_ready,
  input  wire logic [3:0]                  irq_detect,
  input  wire logic                        wake_event,
  input  wire logic                        volt_event,
  input  wire logic                        temp_event,
  output      logic                        supply_sel,
  output      logic                        fro_en,
  output      logic                        bg_en,
  output      logic                        xo_en,
  output      logic [1:0]                  tamper_en,
  output      logic                        timer_run0,
  output      logic                        timer_run1
);
  // register state
  logic [2:0]      osc_q, osc_d;        // fro, bandgap, crystal enables
  logic [1:0]      ten_q, ten_d;        // timer enables
  logic [1:0]      to0_q, to0_d;        // timer 0 period code
  logic [15:0]     to1_q, to1_d;        // timer 1 seconds
  logic [1:0]      sw_q, sw_d;          // active, low power selection
  logic            swl_q, swl_d;        // switch lock
  logic [3:0]      cm_q, cm_d;          // monitor en, div, thresh
  logic            cml_q, cml_d;        // monitor lock
  logic [1:0]      tp_q, tp_d;          // tamper enables
  logic            tpl_q, tpl_d;        // tamper lock
  logic [ST_W-1:0] st_q, st_d;          // sticky flags
  logic            cur_q, cur_d;        // effective active supply
  logic [DATA_W-1:0] rd_q, rd_d;
  logic            por_q;               // power-on flag seed
  logic            exp0, exp1, cm_fault;
  logic [1:0]      run;
  // event pulses and level-following status inputs
  logic [ST_W-1:0] st_set, st_live;

  // timer 0 period code 0..3 maps to 1,2,4,8 s
  logic [15:0] to0_s;
  assign to0_s = 16'h1 << to0_q;

  // [RULE21] bandgap gating of the timers
  assign run = ten_q & {2{osc_q[BIT_BG_EN] & osc_q[BIT_FRO_EN]}};

  bdsup_timer #(.TO_W(16)) u_tmr0 (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .run       (run[0]),
    .tick      (fro_tick),
    .timeout_s (to0_s - 16'h1),
    .expire    (exp0)
  );

  // [RULE5] full 16-bit seconds range
  bdsup_timer #(.TO_W(16)) u_tmr1 (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .run       (run[1]),
    .tick      (fro_tick),
    .timeout_s (to1_q),
    .expire    (exp1)
  );

  // [RULE12] [RULE13] monitor rate and threshold
  bdsup_cmon u_cmon (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .en         (cm_q[BIT_CM_EN]),
    .div_64hz   (cm_q[BIT_CM_DIV]),
    .thresh_sel (cm_q[BIT_CM_FRQ+1:BIT_CM_FRQ]),
    .xo_tick    (xo_tick),
    .fro_tick   (fro_tick),
    .fault      (cm_fault)
  );

  // event sources feeding the sticky status
  always_comb
  begin
    st_set = '0;
    st_set[BIT_ST_POR]  = por_q;
    st_set[BIT_ST_WAKE] = wake_event;
    st_set[BIT_ST_TMR0] = exp0;
    st_set[BIT_ST_TMR1] = exp1;
    st_set[BIT_ST_CMON] = cm_fault;
    // [RULE20] each tamper source only counts when enabled
    st_set[BIT_ST_TAMP] = (volt_event & tp_q[BIT_TP_VOLT])
                        | (temp_event & tp_q[BIT_TP_TEMP]);
    // live flags follow their sources, never cleared by software
    st_live = '0;
    st_live[BIT_ST_LDORDY] = ldo_ready;
    st_live[BIT_ST_XORDY]  = xo_stable;
    st_live[BIT_ST_IRQ0+3:BIT_ST_IRQ0] = irq_detect;
  end

  // register writes and status update
  always_comb
  begin
    osc_d = osc_q;
    ten_d = ten_q;
    to0_d = to0_q;
    to1_d = to1_q;
    sw_d  = sw_q;
    swl_d = swl_q;
    cm_d  = cm_q;
    cml_d = cml_q;
    tp_d  = tp_q;
    tpl_d = tpl_q;
    st_d  = st_q & ~ST_NOCLR_MASK;
    if (wr)
    begin
      case (addr)
        OFF_OSC_CTRL:  osc_d = wdata[2:0];
        OFF_TMR_CMD:
        begin
          // [RULE2] [RULE3] refused unless both running
          if (osc_q[BIT_FRO_EN] && osc_q[BIT_BG_EN])
          begin
            // [RULE1] id mask acts on several timers at once
            if (wdata[BIT_CMD_EN])
              ten_d = ten_q | wdata[BIT_CMD_ID0+1:BIT_CMD_ID0];
            else
              ten_d = ten_q & ~wdata[BIT_CMD_ID0+1:BIT_CMD_ID0];
          end
        end
        // [RULE4] timeout only while that timer is off
        OFF_TMR0_TO:   if (!ten_q[0]) to0_d = wdata[1:0];
        OFF_TMR1_TO:   if (!ten_q[1]) to1_d = wdata[15:0];
        // [RULE9] supply selection frozen under lock
        OFF_SW_CTRL:   if (!swl_q) sw_d = wdata[1:0];
        // [RULE10] lock set by 1, cleared by 0
        OFF_SW_LOCK:   swl_d = wdata[0];
        OFF_CMON_CTRL:
        begin
          // [RULE14] enable bit kept while locked
          cm_d = wdata[3:0];
          if (cml_q)
            cm_d[BIT_CM_EN] = cm_q[BIT_CM_EN];
        end
        OFF_CMON_LOCK: cml_d = wdata[0];
        // [RULE16] [RULE17] tamper mask write unless locked
        OFF_TAMP_EN:   if (!tpl_q) tp_d = wdata[1:0];
        OFF_TAMP_LOCK: tpl_d = wdata[0];
        // [RULE19] masked clear of clearable flags only
        OFF_STATUS:
          st_d = st_q & ~(wdata[ST_W-1:0] & ~ST_NOCLR_MASK);
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    st_d = st_d | st_set;
  end

  // [RULE6] [RULE8] effective active-mode supply
  assign cur_d = (sw_q[BIT_SW_LP] == SUP_SYSTEM) ? SUP_SYSTEM
                                                 : sw_q[BIT_SW_ACT];

  // read mux, data appear in the cycle after the strobe
  always_comb
  begin
    // idle cycles and unmapped words read zero
    rd_d = '0;
    if (rd)
    begin
      case (addr)
        OFF_OSC_CTRL:  rd_d[2:0]  = osc_q;
        OFF_TMR_EN:    rd_d[1:0]  = ten_q;
        OFF_TMR0_TO:   rd_d[1:0]  = to0_q;
        OFF_TMR1_TO:   rd_d[15:0] = to1_q;
        // [RULE7] current supply read back in bit 2
        OFF_SW_CTRL:   rd_d[2:0]  = {cur_q, sw_q};
        OFF_SW_LOCK:   rd_d[0]    = swl_q;
        OFF_CMON_CTRL: rd_d[3:0]  = cm_q;
        OFF_CMON_LOCK: rd_d[0]    = cml_q;
        OFF_TAMP_EN:   rd_d[1:0]  = tp_q;
        OFF_TAMP_LOCK: rd_d[0]    = tpl_q;
        // [RULE18] every flag in one word
        OFF_STATUS:    rd_d[ST_W-1:0] = st_q | st_live;
        default:       ;
      endcase
    end
  end

  // [RULE22] reset clears locks and settings
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_q <= RST_OSC;
      ten_q <= RST_TMR_EN;
      to0_q <= RST_TMR0_TO;
      to1_q <= RST_TMR1_TO;
      sw_q  <= RST_SW;
      swl_q <= 1'b0;
      cm_q  <= RST_CMON;
      cml_q <= 1'b0;
      tp_q  <= RST_TAMP;
      tpl_q <= 1'b0;
      st_q  <= '0;
      cur_q <= SUP_BATTERY;
      rd_q  <= '0;
      por_q <= 1'b1;
    end
    else
    begin
      osc_q <= osc_d;
      ten_q <= ten_d;
      to0_q <= to0_d;
      to1_q <= to1_d;
      sw_q  <= sw_d;
      swl_q <= swl_d;
      cm_q  <= cm_d;
      cml_q <= cml_d;
      tp_q  <= tp_d;
      tpl_q <= tpl_d;
      st_q  <= st_d;
      cur_q <= cur_d;
      rd_q  <= rd_d;
      por_q <= 1'b0;
    end
  end

  // outputs straight from flip-flops
  assign rdata      = rd_q;
  assign supply_sel = cur_q;
  assign fro_en     = osc_q[BIT_FRO_EN];
  assign bg_en      = osc_q[BIT_BG_EN];
  assign xo_en      = osc_q[BIT_XO_EN];
  assign tamper_en  = tp_q;
  assign timer_run0 = ten_q[0];
  assign timer_run1 = ten_q[1];

  // assertions
  sequence cmd_blocked_s;
    wr && addr == OFF_TMR_CMD && !(osc_q[BIT_FRO_EN] && osc_q[BIT_BG_EN]);
  endsequence

  tmr_refuse_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    cmd_blocked_s |=> $stable(ten_q))
    else $error("timer command taken while clocks off");
  tmr_bg_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE21]
    !osc_q[BIT_BG_EN] |=> !exp0 && !exp1)
    else $error("timer expired without bandgap");
  tmr_mask_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    wr && addr == OFF_TMR_CMD && osc_q[1:0] == 2'b11 && wdata[0]
    |=> (ten_q & $past(wdata[2:1])) == $past(wdata[2:1]))
    else $error("timer mask enable lost");
  to_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
    ten_q[1] |=> $stable(to1_q) || !$past(ten_q[1]))
    else $error("timeout changed while timer on");
  sw_lock_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9]
    swl_q |=> $stable(sw_q))
    else $error("switch changed while locked");
  sup_lp_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
    sw_q[BIT_SW_LP] |=> supply_sel == SUP_SYSTEM)
    else $error("low power system choice ignored");
  cm_lock_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE14]
    cml_q |=> $stable(cm_q[BIT_CM_EN]))
    else $error("monitor enable changed while locked");
  tp_lock_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE17]
    tpl_q |=> $stable(tp_q))
    else $error("tamper changed while locked");
  st_keep_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE19]
    exp0 |=> st_q[BIT_ST_TMR0])
    else $error("timer flag lost");
  rd_late_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE18]
    !rd |=> rdata == '0)
    else $error("read data outside answer cycle");
endmodule

// >>> logic/bdsup_pkg.sv
package bdsup_pkg;
  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_OSC_CTRL  = 8'h00;
  localparam logic [7:0] OFF_TMR_EN    = 8'h04;
  localparam logic [7:0] OFF_TMR0_TO   = 8'h08;
  localparam logic [7:0] OFF_TMR1_TO   = 8'h0C;
  localparam logic [7:0] OFF_SW_CTRL   = 8'h10;
  localparam logic [7:0] OFF_SW_LOCK   = 8'h14;
  localparam logic [7:0] OFF_CMON_CTRL = 8'h18;
  localparam logic [7:0] OFF_CMON_LOCK = 8'h1C;
  localparam logic [7:0] OFF_TAMP_EN   = 8'h20;
  localparam logic [7:0] OFF_TAMP_LOCK = 8'h24;
  localparam logic [7:0] OFF_STATUS    = 8'h28;
  localparam logic [7:0] OFF_TMR_CMD   = 8'h2C;

  // oscillator/bandgap control field positions
  localparam int unsigned BIT_FRO_EN  = 0;
  localparam int unsigned BIT_BG_EN   = 1;
  localparam int unsigned BIT_XO_EN   = 2;

  // timer command word: bit 0 enable/disable, bits 2:1 timer id mask
  localparam int unsigned BIT_CMD_EN  = 0;
  localparam int unsigned BIT_CMD_ID0 = 1;

  // supply switch fields: bit 0 active sel, bit 1 low power sel
  localparam int unsigned BIT_SW_ACT  = 0;
  localparam int unsigned BIT_SW_LP   = 1;
  localparam int unsigned BIT_SW_CUR  = 2;

  // clock monitor fields
  localparam int unsigned BIT_CM_EN   = 0;
  localparam int unsigned BIT_CM_DIV  = 1;
  localparam int unsigned BIT_CM_FRQ  = 2;

  // tamper enable bits
  localparam int unsigned BIT_TP_VOLT = 0;
  localparam int unsigned BIT_TP_TEMP = 1;

  // status word layout
  localparam int unsigned BIT_ST_POR    = 0;
  localparam int unsigned BIT_ST_WAKE   = 1;
  localparam int unsigned BIT_ST_TMR0   = 2;
  localparam int unsigned BIT_ST_TMR1   = 3;
  localparam int unsigned BIT_ST_CMON   = 4;
  localparam int unsigned BIT_ST_TAMP   = 5;
  localparam int unsigned BIT_ST_LDORDY = 6;
  localparam int unsigned BIT_ST_XORDY  = 7;
  localparam int unsigned BIT_ST_IRQ0   = 8;
  localparam int unsigned ST_W          = 12;
  // flags software may not clear: regulator, crystal, four irq detects
  localparam logic [11:0] ST_NOCLR_MASK = 12'hFC0;

  // reset values
  localparam logic [2:0]  RST_OSC     = 3'h0;
  localparam logic [1:0]  RST_TMR_EN  = 2'h0;
  localparam logic [1:0]  RST_TMR0_TO = 2'h0;
  localparam logic [15:0] RST_TMR1_TO = 16'h0000;
  localparam logic [1:0]  RST_SW      = 2'h0;
  localparam logic [3:0]  RST_CMON    = 4'h0;
  localparam logic [1:0]  RST_TAMP    = 2'h0;

  // supply selection encoding
  localparam logic SUP_BATTERY = 1'b0;
  localparam logic SUP_SYSTEM  = 1'b1;

  // timing of the 16 kHz tick seen from mclk
  localparam int unsigned OSC16K_HZ  = 16000;
  localparam int unsigned MCLK_HZ    = 100000000;
  localparam int unsigned TICK_CYC   = MCLK_HZ / OSC16K_HZ;
  localparam int unsigned SEC_TICKS  = OSC16K_HZ;
  localparam int unsigned XO_HZ      = 32768;
  localparam int unsigned CM_1K_DIV  = 32;
  localparam int unsigned CM_64_DIV  = 512;
endpackage

// >>> logic/bdsup_timer.sv
// one bandgap wake timer: counts 16 kHz ticks up to a timeout in seconds
module bdsup_timer
  import bdsup_pkg::*;
#(
  parameter int unsigned TO_W = 16
)(
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            run,
  input  wire logic            tick,
  input  wire logic [TO_W-1:0] timeout_s,
  output      logic            expire
);
  // elaboration check: the seconds counter holds at most 16 bits
  if (TO_W < 1 || TO_W > 16)
  begin : g_bad_width
    $error("bdsup_timer: TO_W out of range");
  end

  logic [13:0]     sub_q;   // ticks inside one second
  logic [13:0]     sub_d;
  logic [TO_W-1:0] sec_q;   // whole seconds elapsed
  logic [TO_W-1:0] sec_d;
  logic            exp_q;
  logic            exp_d;

  // count while running; a stopped timer forgets its progress
  always_comb
  begin
    sub_d = sub_q;
    sec_d = sec_q;
    exp_d = 1'b0;
    if (!run)
    begin
      sub_d = '0;
      sec_d = '0;
    end
    else if (tick)
    begin
      if (sub_q == 14'(SEC_TICKS - 1))
      begin
        sub_d = '0;
        if (sec_q >= timeout_s)
        begin
          // zero timeout still fires once per second, never stalls
          exp_d = 1'b1;
          sec_d = '0;
        end
        else
          sec_d = sec_q + 1'b1;
      end
      else
        sub_d = sub_q + 1'b1;
    end
  end

  // state registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_q <= '0;
      sec_q <= '0;
      exp_q <= 1'b0;
    end
    else
    begin
      sub_q <= sub_d;
      sec_q <= sec_d;
      exp_q <= exp_d;
    end
  end

  assign expire = exp_q;
endmodule

// >>> logic/bdsup_cmon.sv
// clock monitor: checks each divided crystal window for a 16k tick, flags fault
module bdsup_cmon
  import bdsup_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       en,
  input  wire logic       div_64hz,
  input  wire logic [1:0] thresh_sel,
  input  wire logic       xo_tick,
  input  wire logic       fro_tick,
  output      logic       fault
);
  logic [9:0] div_q;    // crystal divider
  logic [9:0] div_d;
  logic [3:0] miss_q;   // windows with no 16k activity
  logic [3:0] miss_d;
  logic       seen_q;   // 16k tick seen in current window
  logic       seen_d;
  logic       flt_q;
  logic       flt_d;
  logic [9:0] div_end;
  logic [3:0] limit;

  // threshold 2,4,6,8 windows
  always_comb
  begin
    div_end = div_64hz ? 10'(CM_64_DIV - 1) : 10'(CM_1K_DIV - 1);
    limit   = {thresh_sel, 1'b0} + 4'h2;
    div_d   = div_q;
    miss_d  = miss_q;
    seen_d  = seen_q | fro_tick;
    flt_d   = 1'b0;
    if (!en)
    begin
      div_d  = '0;
      miss_d = '0;
      seen_d = 1'b0;
    end
    else if (xo_tick)
    begin
      if (div_q >= div_end)
      begin
        div_d  = '0;
        seen_d = fro_tick;
        if (seen_q)
          miss_d = '0;
        else if (miss_q + 4'h1 >= limit)
        begin
          flt_d  = 1'b1;
          miss_d = '0;
        end
        else
          miss_d = miss_q + 4'h1;
      end
      else
        div_d = div_q + 1'b1;
    end
  end

  // state registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q  <= '0;
      miss_q <= '0;
      seen_q <= 1'b0;
      flt_q  <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      miss_q <= miss_d;
      seen_q <= seen_d;
      flt_q  <= flt_d;
    end
  end

  assign fault = flt_q;
endmodule

// >>> tb/test_battery_domain_supervisor.sv
module test_battery_domain_supervisor;
  timeunit 1ns;
  timeprecision 100ps;
  import bdsup_pkg::*;

  // bus, tick and event drive, all owned by the bench
  logic                mclk;
  logic                rst_n;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   rdata;
  logic                wr;
  logic                rd;
  logic                fro_tick;
  logic                xo_tick;
  logic                xo_stable;
  logic                ldo_ready;
  logic [3:0]          irq_detect;
  logic                wake_event;
  logic                volt_event;
  logic                temp_event;
  logic                supply_sel;
  logic                fro_en;
  logic                bg_en;
  logic                xo_en;
  logic [1:0]          tamper_en;
  logic                timer_run0;
  logic                timer_run1;
  int                  fail_count;
  int                  checks;

  bdsup_top u_dut (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .addr       (addr),
    .wdata      (wdata),
    .wr         (wr),
    .rd         (rd),
    .rdata      (rdata),
    .fro_tick   (fro_tick),
    .xo_tick    (xo_tick),
    .xo_stable  (xo_stable),
    .ldo_ready  (ldo_ready),
    .irq_detect (irq_detect),
    .wake_event (wake_event),
    .volt_event (volt_event),
    .temp_event (temp_event),
    .supply_sel (supply_sel),
    .fro_en     (fro_en),
    .bg_en      (bg_en),
    .xo_en      (xo_en),
    .tamper_en  (tamper_en),
    .timer_run0 (timer_run0),
    .timer_run1 (timer_run1)
  );

  // free-running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // one compare for every kind of result; unknowns never match
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %0h seen %0h", name, exp, got);
      fail_count++;
    end
  endtask

  // single-cycle write; the strobe drops at the edge that takes it
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd_val(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] v;
    rd_val(a, v);
    chk(name, exp, v);
  endtask

  // let registered outputs settle; supply select lags one cycle
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // crystal ticks on every cycle for n cycles, then quiet
  task automatic xo_burst(input int n);
    @(posedge mclk);
    xo_tick <= 1'b1;
    repeat (n) @(posedge mclk);
    xo_tick <= 1'b0;
  endtask

  task automatic close_out();
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // control registers except monitor lock and tamper enable, and an unmapped word, read zero after reset
  task automatic reset_values();
    logic [7:0] offs [9];
    offs = '{OFF_OSC_CTRL, OFF_TMR_EN, OFF_TMR0_TO, OFF_TMR1_TO, OFF_SW_CTRL,
             OFF_SW_LOCK, OFF_CMON_CTRL, OFF_TAMP_LOCK, 8'h3C};
    foreach (offs[i])
      rd_chk("reset word", offs[i], 32'h0);
    chk("reset pins", 32'h0, {supply_sel, fro_en, tamper_en});
  endtask

  // sticky and live flags in one word; live ones survive a full clear
  task automatic status_word();
    @(posedge mclk);
    ldo_ready  <= 1'b1;
    xo_stable  <= 1'b1;
    irq_detect <= 4'hA;
    wake_event <= 1'b1;
    @(posedge mclk);
    wake_event <= 1'b0;
    rd_chk("status", OFF_STATUS, 32'hAC3);
    wr_reg(OFF_STATUS, 32'hFFF);
    rd_chk("status cleared", OFF_STATUS, 32'hAC0);
  endtask

  // supply switch selections, readback of current supply and its lock
  task automatic supply_switch();
    wr_reg(OFF_SW_CTRL, 32'h1);
    settle();
    chk("supply pin", 32'h1, supply_sel);
    rd_chk("switch word", OFF_SW_CTRL, 32'h5);
    wr_reg(OFF_SW_CTRL, 32'h2);
    settle();
    chk("lp supply pin", 32'h1, supply_sel);
    rd_chk("lp switch word", OFF_SW_CTRL, 32'h6);
    wr_reg(OFF_SW_CTRL, 32'h0);
    wr_reg(OFF_SW_LOCK, 32'h1);
    rd_chk("switch lock", OFF_SW_LOCK, 32'h1);
    wr_reg(OFF_SW_CTRL, 32'h1);
    settle();
    chk("locked supply pin", 32'h0, supply_sel);
    rd_chk("locked switch", OFF_SW_CTRL, 32'h0);
    wr_reg(OFF_SW_LOCK, 32'h0);
    rd_chk("switch unlock", OFF_SW_LOCK, 32'h0);
    wr_reg(OFF_SW_CTRL, 32'h1);
    rd_chk("unlocked switch", OFF_SW_CTRL, 32'h5);
  endtask

  // every divide and threshold code, the enable lock, then empty windows
  task automatic clock_monitor();
    logic [31:0] v;
    wr_reg(OFF_OSC_CTRL, 32'h7);
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(OFF_CMON_CTRL, 32'(i << 1));
      rd_chk("monitor trims", OFF_CMON_CTRL, 32'(i << 1));
    end
    wr_reg(OFF_CMON_CTRL, 32'h1);
    wr_reg(OFF_CMON_LOCK, 32'h1);
    rd_chk("monitor lock", OFF_CMON_LOCK, 32'h1);
    wr_reg(OFF_CMON_CTRL, 32'h2);
    rd_chk("locked monitor", OFF_CMON_CTRL, 32'h3);
    wr_reg(OFF_CMON_LOCK, 32'h0);
    wr_reg(OFF_CMON_CTRL, 32'h0);
    rd_chk("unlocked monitor", OFF_CMON_CTRL, 32'h0);
    // no 16k tick: fault after two empty 1 kHz windows, not after one
    wr_reg(OFF_CMON_CTRL, 32'h1);
    wr_reg(OFF_STATUS, 32'hFFF);
    xo_burst(CM_1K_DIV + 8);
    rd_val(OFF_STATUS, v);
    chk("one window", 32'h0, v & 32'h10);
    xo_burst(CM_1K_DIV + 8);
    rd_val(OFF_STATUS, v);
    chk("two windows", 32'h10, v & 32'h10);
    // the 64 Hz rate needs far more crystal ticks per window
    wr_reg(OFF_CMON_CTRL, 32'h0);
    wr_reg(OFF_CMON_CTRL, 32'h3);
    wr_reg(OFF_STATUS, 32'hFFF);
    xo_burst(2 * CM_1K_DIV + 8);
    rd_val(OFF_STATUS, v);
    chk("slow windows", 32'h0, v & 32'h10);
  endtask

  // every tamper mask code, the tamper lock, then the voltage source on its own
  task automatic tamper();
    logic [31:0] v;
    // oscillator and bandgap still on from the monitor setup
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(OFF_TAMP_EN, 32'(i));
      rd_chk("tamper mask", OFF_TAMP_EN, 32'(i));
      chk("tamper pins", 32'(i), tamper_en);
    end
    wr_reg(OFF_TAMP_LOCK, 32'h1);
    rd_chk("tamper lock", OFF_TAMP_LOCK, 32'h1);
    wr_reg(OFF_TAMP_EN, 32'h0);
    rd_chk("locked tamper", OFF_TAMP_EN, 32'h3);
    wr_reg(OFF_TAMP_LOCK, 32'h0);
    wr_reg(OFF_TAMP_EN, 32'h0);
    rd_chk("unlocked tamper", OFF_TAMP_EN, 32'h0);
    // voltage source only: a temperature event must not flag
    wr_reg(OFF_TAMP_EN, 32'h1);
    wr_reg(OFF_STATUS, 32'hFFF);
    @(posedge mclk);
    temp_event <= 1'b1;
    @(posedge mclk);
    temp_event <= 1'b0;
    rd_val(OFF_STATUS, v);
    chk("masked tamper flag", 32'h0, v & 32'h20);
    @(posedge mclk);
    volt_event <= 1'b1;
    @(posedge mclk);
    volt_event <= 1'b0;
    rd_val(OFF_STATUS, v);
    chk("tamper flag", 32'h20, v & 32'h20);
  endtask

  // timer commands need both oscillator and bandgap; timeouts need idle
  task automatic timers();
    wr_reg(OFF_OSC_CTRL, 32'h1);
    wr_reg(OFF_TMR_CMD, 32'h7);
    rd_chk("no bandgap", OFF_TMR_EN, 32'h0);
    wr_reg(OFF_OSC_CTRL, 32'h2);
    wr_reg(OFF_TMR_CMD, 32'h7);
    rd_chk("no oscillator", OFF_TMR_EN, 32'h0);
    wr_reg(OFF_OSC_CTRL, 32'h3);
    wr_reg(OFF_TMR_CMD, 32'h7);
    rd_chk("both timers", OFF_TMR_EN, 32'h3);
    chk("run pins", 32'hF, {xo_en, bg_en, fro_en, timer_run1, timer_run0});
    wr_reg(OFF_TMR1_TO, 32'h1234);
    wr_reg(OFF_TMR0_TO, 32'h3);
    rd_chk("busy timeout1", OFF_TMR1_TO, 32'h0);
    rd_chk("busy timeout0", OFF_TMR0_TO, 32'h0);
    wr_reg(OFF_TMR_CMD, 32'h4);
    rd_chk("timer1 off", OFF_TMR_EN, 32'h1);
    wr_reg(OFF_TMR1_TO, 32'hFFFF);
    rd_chk("max timeout", OFF_TMR1_TO, 32'hFFFF);
  endtask

  // both timers at zero timeout expire after one second of 16k ticks
  task automatic expiry();
    logic [31:0] v;
    int          n;
    wr_reg(OFF_TMR_CMD, 32'h2);
    wr_reg(OFF_TMR1_TO, 32'h0);
    wr_reg(OFF_STATUS, 32'hFFF);
    wr_reg(OFF_TMR_CMD, 32'h7);
    fro_tick <= 1'b1;
    v = 32'h0;
    n = 0;
    while (v[BIT_ST_TMR1] !== 1'b1 && n < 9000)
    begin
      rd_val(OFF_STATUS, v);
      n++;
    end
    fro_tick <= 1'b0;
    if (n >= 9000)
    begin
      $display("Error expiry wait expected flag seen timeout");
      fail_count++;
      close_out();
    end
    else
    begin
      chk("expiry flags", 32'hC, v & 32'hC);
      // one read per two cycles; the flag lands a cycle after the last tick
      chk("expiry reads", 32'(SEC_TICKS / 2 + 1), 32'(n));
    end
  endtask

  // a second reset in mid-run drops every lock and selection
  task automatic relock_reset();
    wr_reg(OFF_SW_LOCK, 32'h1);
    wr_reg(OFF_CMON_LOCK, 32'h1);
    wr_reg(OFF_TAMP_LOCK, 32'h1);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk("switch lock", OFF_SW_LOCK, 32'h0);
    rd_chk("monitor lock", OFF_CMON_LOCK, 32'h0);
    rd_chk("tamper lock", OFF_TAMP_LOCK, 32'h0);
    rd_chk("switch word", OFF_SW_CTRL, 32'h0);
    chk("pins", 32'h0, {supply_sel, timer_run1, bg_en});
  endtask

  // main sequence: reset held 12 cycles, then each scenario in turn
  initial
  begin
    fail_count = 0;
    checks     = 0;
    rst_n      = 1'b0;
    addr       = 8'h00;
    wdata      = 32'h0;
    wr         = 1'b0;
    rd         = 1'b0;
    fro_tick   = 1'b0;
    xo_tick    = 1'b0;
    xo_stable  = 1'b0;
    ldo_ready  = 1'b0;
    irq_detect = 4'h0;
    wake_event = 1'b0;
    volt_event = 1'b0;
    temp_event = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    reset_values();
    status_word();
    supply_switch();
    clock_monitor();
    tamper();
    timers();
    expiry();
    relock_reset();
    close_out();
  end
endmodule
